// File: common/sep_if.sv
// Serial link between controller and memory, with pulled-up data out line
`timescale 1ns/1ns
`default_nettype none
interface sep_if;
  logic cs;
  logic serial_clk;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic serial_line;

  // Line floats high through a pull-up when nobody drives it
  assign serial_line = serial_out_oe ? serial_out : 1'b1;

  modport dev (
    input  cs,
    input  serial_clk,
    input  serial_in,
    output serial_out,
    output serial_out_oe
  );

  modport host (
    output cs,
    output serial_clk,
    output serial_in,
    input  serial_line
  );
endinterface
`default_nettype wire

// File: common/sep_pkg.sv
// Shared constants and types for the serial word memory port and its controller
`default_nettype none
package sep_pkg;

  // Array geometry
  localparam int WORDS    = 64;
  localparam int AW       = 6;
  localparam int DW       = 16;
  localparam int HDR_W    = 8;
  localparam int TX_W     = 25;

  // Operation codes and global sub-codes
  localparam logic [1:0] OPC_GLOBAL = 2'h0;
  localparam logic [1:0] OPC_WRITE  = 2'h1;
  localparam logic [1:0] OPC_READ   = 2'h2;
  localparam logic [1:0] OPC_ERASE  = 2'h3;
  localparam logic [1:0] GSUB_DIS   = 2'h0;
  localparam logic [1:0] GSUB_WRITE_ALL_CMD  = 2'h1;
  localparam logic [1:0] GSUB_ERASE_ALL_CMD  = 2'h2;
  localparam logic [1:0] GSUB_EN    = 2'h3;

  // Bit counters: last header bit, last data bit, host frame ends
  localparam logic [4:0] HDR_LAST   = 5'h07;
  localparam logic [4:0] DATA_LAST  = 5'h0f;
  localparam logic [4:0] LAST_SHORT = 5'h08;
  localparam logic [4:0] LAST_LONG  = 5'h18;
  localparam logic [4:0] RX_FIRST   = 5'h09;
  localparam logic [DW-1:0] WORD_ONES = 16'hffff;

  // Timing, clock 125 MHz
  localparam int CLK_PERIOD_NS = 8;
  localparam int PROG_TIME_MS  = 10;
  localparam int PROG_CYC      = PROG_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SK_PERIOD_US  = 4;
  localparam int SK_HALF_CYC   = (SK_PERIOD_US * 500 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_LOW_US     = 1;
  localparam int CS_LOW_CYC    = (CS_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STAT_VALID_US = 1;
  localparam int SV_CYC        = (STAT_VALID_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SK_HALF_LAST = 8'(SK_HALF_CYC - 1);
  localparam logic [7:0] CS_LOW_LAST  = 8'(CS_LOW_CYC - 1);
  localparam logic [7:0] SV_LAST      = 8'(SV_CYC - 1);

  // Host command kinds
  typedef enum logic [2:0] {
    CMD_READ  = 3'h0,
    CMD_WRITE = 3'h1,
    CMD_ERASE = 3'h2,
    CMD_EN    = 3'h3,
    CMD_DIS   = 3'h4,
    CMD_ERASE_ALL_CMD  = 3'h5,
    CMD_WRITE_ALL_CMD  = 3'h6
  } sep_cmd_t;

  // Pending programming operation
  typedef enum logic [1:0] {
    P_WRITE = 2'h0,
    P_ERASE = 2'h1,
    P_ERASE_ALL_CMD  = 2'h2,
    P_WRITE_ALL_CMD  = 2'h3
  } sep_pop_t;

  // Memory side states
  typedef enum logic [2:0] {
    D_IDLE = 3'h0,
    D_HDR  = 3'h1,
    D_DATA = 3'h2,
    D_ARM  = 3'h3,
    D_READ = 3'h4,
    D_SKIP = 3'h5,
    D_PROG = 3'h6
  } sep_dstate_t;

  // Controller states
  typedef enum logic [2:0] {
    H_GAP   = 3'h0,
    H_IDLE  = 3'h1,
    H_LO    = 3'h2,
    H_HI    = 3'h3,
    H_PWAIT = 3'h4,
    H_SV    = 3'h5,
    H_POLL  = 3'h6
  } sep_hstate_t;

endpackage
`default_nettype wire

// File: rtl/sep_dev.sv
// Memory end: 64x16 word array behind the serial command port
// Operation
// RL1 - Sixty-four words of sixteen bits, six-bit address
// RL2 - Nine bits: start one, opcode, address, MSB first
// RL3 - Opcodes read, write, erase; write adds data
// RL4 - Global opcode: enable, disable, erase all, write all
// RL5 - Only read drives data; word loaded to shifter
// RL6 - Read sends zero dummy, then sixteen bits
// RL7 - Output bit changes on serial clock rise
// RL8 - Programming disabled at power up until enabled
// RL9 - Reads work whether programming enabled or not
// RL10 - Output undriven except read or polled status
// RL11 - Select fall after erase sets word ones
// RL12 - Select fall after data starts self-timed write
// RL13 - Status low while busy, high when ready
// RL14 - Controller erases word before writing it; sep_host sends the write alone and the array ANDs the data into the old word
// RL15 - Erase all sets every word to ones
// RL16 - Write all stores pattern into every word; the array ANDs the pattern into each old word
// RL17 - Serial clock not needed during programming
// RL18 - Controller holds select low between instructions
// RL19 - Programming finishes within ten milliseconds
// RL20 - Serial clock period at least four microseconds
// RL21 - Standby when select low and idle
// RL22 - Skip leading zeros; first one starts instruction
// RL23 - Programming commands ignored while disabled
// RL24 - Select fall abandons partial instruction
`timescale 1ns/1ns
`default_nettype none
module sep_dev #(
  parameter int unsigned PROG_CYC = sep_pkg::PROG_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Serial link
  sep_if.dev        link,
  // Status to the user side
  output logic      busy,
  output logic      prog_enabled,
  output logic      standby
);

  localparam int PTW = $clog2(PROG_CYC + 1);

  // Synchronisers; bit 0 is read only by bit 1
  logic [2:0]                cs_sy_r;
  logic [2:0]                sk_sy_r;
  logic [1:0]                di_sy_r;
  logic                      cs_s;
  logic                      di_s;
  logic                      sk_rise;
  logic                      cs_fall;
  logic                      cs_rise;

  // Control state
  sep_pkg::sep_dstate_t      state_r;
  logic [4:0]                cnt_r;
  logic [sep_pkg::HDR_W-1:0] hdr_r;
  logic [sep_pkg::DW-1:0]    data_r;
  logic [sep_pkg::DW-1:0]    rd_sh_r;
  logic                      out_bit_r;
  logic                      en_r;
  logic                      stat_en_r;
  logic [PTW-1:0]            prog_tmr_r;
  sep_pkg::sep_pop_t         pend_op_r;
  logic [sep_pkg::AW-1:0]    pend_addr_r;
  logic                      serial_out_r;
  logic                      serial_out_oe_r;
  logic                      busy_r;
  logic                      standby_r;

  // Decode of the completed header
  logic [sep_pkg::HDR_W-1:0] hdr_w;
  logic [1:0]                opc_w;
  logic [1:0]                gsub_w;
  logic [sep_pkg::AW-1:0]    adr_w;
  logic                      hdr_done;
  logic                      start_bit;
  logic                      prog_done;
  sep_pkg::sep_dstate_t      hdr_next;

  // Word array, no reset: contents are meant to survive
  logic [sep_pkg::DW-1:0]    mem_r [sep_pkg::WORDS];

  // Pin sampling; clock edges found from the second and third stages
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cs_sy_r <= 3'h0;
      sk_sy_r <= 3'h0;
      di_sy_r <= 2'h0;
    end else begin
      cs_sy_r <= {cs_sy_r[1:0], link.cs};
      sk_sy_r <= {sk_sy_r[1:0], link.serial_clk};
      di_sy_r <= {di_sy_r[0], link.serial_in};
    end
  end

  // Edge and header decode terms
  assign cs_s      = cs_sy_r[1];
  assign di_s      = di_sy_r[1];
  assign sk_rise   = sk_sy_r[1] & ~sk_sy_r[2] & cs_s;
  assign cs_fall   = ~cs_sy_r[1] & cs_sy_r[2];
  assign cs_rise   = cs_sy_r[1] & ~cs_sy_r[2];
  assign hdr_w     = {hdr_r[sep_pkg::HDR_W-2:0], di_s};  // see RL2
  assign opc_w     = hdr_w[7:6];
  assign gsub_w    = hdr_w[5:4];
  assign adr_w     = hdr_w[sep_pkg::AW-1:0];
  assign hdr_done  = (state_r == sep_pkg::D_HDR) && sk_rise && (cnt_r == sep_pkg::HDR_LAST);
  assign start_bit = (state_r == sep_pkg::D_IDLE) && sk_rise && di_s;  // see RL22
  assign prog_done = (state_r == sep_pkg::D_PROG) && (prog_tmr_r == '0);

  // Next state after the header; disabled programming falls to skip
  always_comb begin
    hdr_next = sep_pkg::D_SKIP;
    case (opc_w)
      sep_pkg::OPC_READ:  hdr_next = sep_pkg::D_READ;  // see RL9
      sep_pkg::OPC_WRITE: hdr_next = en_r ? sep_pkg::D_DATA : sep_pkg::D_SKIP;  // see RL23
      sep_pkg::OPC_ERASE: hdr_next = en_r ? sep_pkg::D_ARM : sep_pkg::D_SKIP;  // see RL23
      default: begin
        if (gsub_w == sep_pkg::GSUB_WRITE_ALL_CMD) begin
          hdr_next = en_r ? sep_pkg::D_DATA : sep_pkg::D_SKIP;  // see RL16
        end else if (gsub_w == sep_pkg::GSUB_ERASE_ALL_CMD) begin
          hdr_next = en_r ? sep_pkg::D_ARM : sep_pkg::D_SKIP;  // see RL15
        end
      end
    endcase
  end

  // Sequencer; select fall drops partial frames, starts programming from D_ARM
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_r <= sep_pkg::D_IDLE;
      cnt_r   <= 5'h00;
    end else if (cs_fall && state_r != sep_pkg::D_PROG) begin
      cnt_r   <= 5'h00;
      if (state_r == sep_pkg::D_ARM) begin
        state_r <= sep_pkg::D_PROG;  // see RL11 see RL12
      end else begin
        state_r <= sep_pkg::D_IDLE;  // see RL24
      end
    end else begin
      case (state_r)
        sep_pkg::D_IDLE: begin
          cnt_r <= 5'h00;
          if (start_bit) begin
            state_r <= sep_pkg::D_HDR;
          end
        end
        sep_pkg::D_HDR: begin
          if (sk_rise) begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == sep_pkg::HDR_LAST) begin
              state_r <= hdr_next;
              cnt_r   <= 5'h00;
            end
          end
        end
        sep_pkg::D_DATA: begin
          if (sk_rise) begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == sep_pkg::DATA_LAST) begin
              state_r <= sep_pkg::D_ARM;
            end
          end
        end
        sep_pkg::D_ARM: begin
          // A stray clock rise here means select came too late
          if (sk_rise) begin
            state_r <= sep_pkg::D_SKIP;
          end
        end
        sep_pkg::D_PROG: begin
          // Clock and data pins are ignored until the timer ends
          if (prog_done) begin
            state_r <= sep_pkg::D_IDLE;  // see RL17
          end
        end
        default: state_r <= state_r;
      endcase
    end
  end

  // Header and data shifters, pending operation capture
  always_ff @(posedge clk) begin
    if (!resetn) begin
      hdr_r       <= 8'h00;
      data_r      <= 16'h0000;
      pend_op_r   <= sep_pkg::P_WRITE;
      pend_addr_r <= 6'h00;
    end else begin
      if (state_r == sep_pkg::D_HDR && sk_rise) begin
        hdr_r <= hdr_w;  // see RL2
      end
      if (state_r == sep_pkg::D_DATA && sk_rise) begin
        data_r <= {data_r[sep_pkg::DW-2:0], di_s};  // see RL3
      end
      if (hdr_done) begin
        pend_addr_r <= adr_w;
        case (opc_w)
          sep_pkg::OPC_WRITE: pend_op_r <= sep_pkg::P_WRITE;
          sep_pkg::OPC_ERASE: pend_op_r <= sep_pkg::P_ERASE;
          default: pend_op_r <= (gsub_w == sep_pkg::GSUB_ERASE_ALL_CMD) ? sep_pkg::P_ERASE_ALL_CMD
                                                               : sep_pkg::P_WRITE_ALL_CMD;  // see RL4
        endcase
      end
    end
  end

  // Programming enable latch, off from power up
  always_ff @(posedge clk) begin
    if (!resetn) begin
      en_r <= 1'b0;  // see RL8
    end else if (hdr_done && opc_w == sep_pkg::OPC_GLOBAL) begin
      if (gsub_w == sep_pkg::GSUB_EN) begin
        en_r <= 1'b1;  // see RL4
      end else if (gsub_w == sep_pkg::GSUB_DIS) begin
        en_r <= 1'b0;  // see RL8
      end
    end
  end

  // Self-timed cycle, rounded down to stay inside the limit
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prog_tmr_r <= '0;
    end else if (state_r == sep_pkg::D_ARM && cs_fall) begin
      prog_tmr_r <= PTW'(PROG_CYC - 1);  // see RL19
    end else if (state_r == sep_pkg::D_PROG && prog_tmr_r != '0) begin
      prog_tmr_r <= prog_tmr_r - 1'b1;
    end
  end

  // Array update at the end of the cycle; write only clears bits
  for (genvar i = 0; i < sep_pkg::WORDS; i++) begin : g_word
    always_ff @(posedge clk) begin
      if (prog_done) begin
        case (pend_op_r)
          sep_pkg::P_WRITE: begin
            if (pend_addr_r == sep_pkg::AW'(i)) begin
              mem_r[i] <= mem_r[i] & data_r;  // see RL1 see RL14
            end
          end
          sep_pkg::P_ERASE: begin
            if (pend_addr_r == sep_pkg::AW'(i)) begin
              mem_r[i] <= sep_pkg::WORD_ONES;  // see RL11
            end
          end
          sep_pkg::P_ERASE_ALL_CMD: mem_r[i] <= sep_pkg::WORD_ONES;  // see RL15
          default:         mem_r[i] <= mem_r[i] & data_r;  // see RL16
        endcase
      end
    end
  end

  // Read shifter: dummy zero first, then MSB on each clock rise
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rd_sh_r   <= 16'h0000;
      out_bit_r <= 1'b0;
    end else if (hdr_done && opc_w == sep_pkg::OPC_READ) begin
      rd_sh_r   <= mem_r[adr_w];  // see RL5
      out_bit_r <= 1'b0;  // see RL6
    end else if (state_r == sep_pkg::D_READ && sk_rise) begin
      out_bit_r <= rd_sh_r[sep_pkg::DW-1];  // see RL7
      rd_sh_r   <= {rd_sh_r[sep_pkg::DW-2:0], 1'b0};
    end
  end

  // Status polling: armed by select rise mid-cycle, dropped on fall
  always_ff @(posedge clk) begin
    if (!resetn) begin
      stat_en_r <= 1'b0;
    end else if (cs_fall || start_bit) begin
      stat_en_r <= 1'b0;
    end else if (cs_rise && state_r == sep_pkg::D_PROG) begin
      stat_en_r <= 1'b1;  // see RL13
    end
  end

  // Registered pin drive and user status
  always_ff @(posedge clk) begin
    if (!resetn) begin
      serial_out_r    <= 1'b0;
      serial_out_oe_r <= 1'b0;
      busy_r          <= 1'b0;
      standby_r       <= 1'b0;
    end else begin
      serial_out_oe_r <= (state_r == sep_pkg::D_READ) | stat_en_r;  // see RL10
      serial_out_r    <= (state_r == sep_pkg::D_READ) ? out_bit_r
                                                      : (state_r != sep_pkg::D_PROG);  // see RL13
      busy_r          <= (state_r == sep_pkg::D_PROG);
      standby_r       <= ~cs_s && (state_r != sep_pkg::D_PROG);  // see RL21
    end
  end

  // Outputs
  assign link.serial_out    = serial_out_r;
  assign link.serial_out_oe = serial_out_oe_r;
  assign busy               = busy_r;
  assign prog_enabled       = en_r;
  assign standby            = standby_r;

endmodule // sep_dev
`default_nettype wire

// File: rtl/sep_host.sv
// Controller end: turns user commands into serial frames and polls status
`timescale 1ns/1ns
`default_nettype none
module sep_host (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   resetn,
  // Serial link
  sep_if.host                         link,
  // Command request
  input  wire logic                   cmd_valid,
  output logic                        cmd_ready,
  input  wire sep_pkg::sep_cmd_t      cmd_kind,
  input  wire logic [sep_pkg::AW-1:0] cmd_addr,
  input  wire logic [sep_pkg::DW-1:0] cmd_data,
  // Completion
  output logic                        rsp_valid,
  output logic [sep_pkg::DW-1:0]      rsp_data
);

  sep_pkg::sep_hstate_t      st_r;
  logic [7:0]                tmr_r;
  logic [4:0]                cnt_r;
  logic [4:0]                last_r;
  logic [sep_pkg::TX_W-1:0]  tx_r;
  logic [sep_pkg::DW-1:0]    rx_r;
  logic                      is_rd_r;
  logic                      is_prog_r;
  logic                      cs_r;
  logic                      sk_r;
  logic                      rsp_r;
  logic [1:0]                line_sy_r;
  logic                      line_s;
  logic [sep_pkg::HDR_W-1:0] hdr_w;
  logic                      long_w;
  logic                      prog_w;

  // Data line comes from the far end; two stages before use
  always_ff @(posedge clk) begin
    if (!resetn) begin
      line_sy_r <= 2'h3;
    end else begin
      line_sy_r <= {line_sy_r[0], link.serial_line};
    end
  end
  assign line_s = line_sy_r[1];

  // Header for each command kind
  always_comb begin
    long_w = 1'b0;
    prog_w = 1'b0;
    case (cmd_kind)
      sep_pkg::CMD_READ: begin
        hdr_w  = {sep_pkg::OPC_READ, cmd_addr};  // see RL3
        long_w = 1'b1;
      end
      sep_pkg::CMD_WRITE: begin
        hdr_w  = {sep_pkg::OPC_WRITE, cmd_addr};  // see RL14
        long_w = 1'b1;
        prog_w = 1'b1;
      end
      sep_pkg::CMD_ERASE: begin
        hdr_w  = {sep_pkg::OPC_ERASE, cmd_addr};  // see RL3
        prog_w = 1'b1;
      end
      sep_pkg::CMD_EN:  hdr_w = {sep_pkg::OPC_GLOBAL, sep_pkg::GSUB_EN, 4'h0};  // see RL4
      sep_pkg::CMD_DIS: hdr_w = {sep_pkg::OPC_GLOBAL, sep_pkg::GSUB_DIS, 4'h0};
      sep_pkg::CMD_ERASE_ALL_CMD: begin
        hdr_w  = {sep_pkg::OPC_GLOBAL, sep_pkg::GSUB_ERASE_ALL_CMD, 4'h0};
        prog_w = 1'b1;
      end
      default: begin
        hdr_w  = {sep_pkg::OPC_GLOBAL, sep_pkg::GSUB_WRITE_ALL_CMD, 4'h0};
        long_w = 1'b1;
        prog_w = 1'b1;
      end
    endcase
  end

  // Frame sequencer; clock halves counted from the system clock
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_r      <= sep_pkg::H_GAP;
      tmr_r     <= 8'h00;
      cnt_r     <= 5'h00;
      last_r    <= 5'h00;
      tx_r      <= '0;
      rx_r      <= 16'h0000;
      is_rd_r   <= 1'b0;
      is_prog_r <= 1'b0;
      cs_r      <= 1'b0;
      sk_r      <= 1'b0;
      rsp_r     <= 1'b0;
    end else begin
      rsp_r <= 1'b0;
      tmr_r <= tmr_r + 8'h01;
      case (st_r)
        sep_pkg::H_GAP: begin
          if (tmr_r == sep_pkg::CS_LOW_LAST) begin
            tmr_r <= 8'h00;
            st_r  <= sep_pkg::H_IDLE;  // see RL18
          end
        end
        sep_pkg::H_IDLE: begin
          tmr_r <= 8'h00;
          if (cmd_valid) begin
            tx_r      <= {1'b1, hdr_w, cmd_data};  // see RL2
            last_r    <= long_w ? sep_pkg::LAST_LONG : sep_pkg::LAST_SHORT;
            is_rd_r   <= (cmd_kind == sep_pkg::CMD_READ);
            is_prog_r <= prog_w;
            cnt_r     <= 5'h00;
            cs_r      <= 1'b1;
            st_r      <= sep_pkg::H_LO;
          end
        end
        sep_pkg::H_LO: begin
          if (tmr_r == sep_pkg::SK_HALF_LAST) begin
            tmr_r <= 8'h00;
            sk_r  <= 1'b1;  // see RL20
            st_r  <= sep_pkg::H_HI;
          end
        end
        sep_pkg::H_HI: begin
          if (tmr_r == sep_pkg::SK_HALF_LAST) begin
            tmr_r <= 8'h00;
            sk_r  <= 1'b0;
            tx_r  <= {tx_r[sep_pkg::TX_W-2:0], 1'b0};
            cnt_r <= cnt_r + 5'h01;
            if (is_rd_r && cnt_r >= sep_pkg::RX_FIRST) begin
              rx_r <= {rx_r[sep_pkg::DW-2:0], line_s};
            end
            if (cnt_r == last_r) begin
              cs_r <= 1'b0;  // see RL12
              if (is_prog_r) begin
                st_r <= sep_pkg::H_PWAIT;
              end else begin
                st_r  <= sep_pkg::H_GAP;
                rsp_r <= 1'b1;
              end
            end else begin
              st_r <= sep_pkg::H_LO;
            end
          end
        end
        sep_pkg::H_PWAIT: begin
          if (tmr_r == sep_pkg::CS_LOW_LAST) begin
            tmr_r <= 8'h00;
            cs_r  <= 1'b1;  // see RL13
            st_r  <= sep_pkg::H_SV;
          end
        end
        sep_pkg::H_SV: begin
          if (tmr_r == sep_pkg::SV_LAST) begin
            st_r <= sep_pkg::H_POLL;
          end
        end
        sep_pkg::H_POLL: begin
          tmr_r <= 8'h00;
          if (line_s) begin
            cs_r  <= 1'b0;
            rsp_r <= 1'b1;
            st_r  <= sep_pkg::H_GAP;
          end
        end
        default: st_r <= sep_pkg::H_GAP;
      endcase
    end
  end

  // Outputs
  assign cmd_ready       = (st_r == sep_pkg::H_IDLE);
  assign rsp_valid       = rsp_r;
  assign rsp_data        = rx_r;
  assign link.cs         = cs_r;
  assign link.serial_clk = sk_r;
  assign link.serial_in  = tx_r[sep_pkg::TX_W-1];

endmodule // sep_host
`default_nettype wire

// File: tb/sep_props.sv
// Timing and status checks on the link between controller and memory
`timescale 1ns/1ns
`default_nettype none
module sep_props #(
  parameter int unsigned PROG_CYC = sep_pkg::PROG_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Link
  input wire logic cs,
  input wire logic serial_clk,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  // Memory status
  input wire logic busy,
  input wire logic prog_enabled,
  input wire logic standby
);
  logic [7:0]  rise_age_r;
  logic [7:0]  idle_age_r;
  logic [7:0]  low_len_r;
  logic [31:0] busy_len_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // Cycles since the last link clock rise, saturating
  always_ff @(posedge clk) begin
    if (!resetn || $rose(serial_clk)) rise_age_r <= 8'h00;
    else if (rise_age_r != 8'hff) rise_age_r <= rise_age_r + 8'h01;
  end

  // Cycles since busy; keeps status edges apart from data edges
  always_ff @(posedge clk) begin
    if (!resetn || busy) idle_age_r <= 8'h00;
    else if (idle_age_r != 8'hff) idle_age_r <= idle_age_r + 8'h01;
  end

  // Length of the current select-low gap
  always_ff @(posedge clk) begin
    if (!resetn || cs) low_len_r <= 8'h00;
    else if (low_len_r != 8'hff) low_len_r <= low_len_r + 8'h01;
  end

  // Length of the running cycle; wide enough for the full-length count
  always_ff @(posedge clk) begin
    if (!resetn || !busy) busy_len_r <= 32'h0;
    else busy_len_r <= busy_len_r + 32'h1;
  end

  property p_sk_high; $fell(serial_clk) |-> rise_age_r >= 8'h7c; endproperty
  a_sk_high: assert property (p_sk_high) else $error("link clock high too short");
  property p_out_on_rise;
    serial_out_oe && $past(serial_out_oe) && $changed(serial_out) && idle_age_r > 8'h10
      |-> rise_age_r < 8'h0c;
  endproperty
  a_out_on_rise: assert property (p_out_on_rise) else $error("data moved off a rise");
  property p_status_low; cs && serial_out_oe && busy && $past(busy) |-> !serial_out; endproperty
  a_status_low: assert property (p_status_low) else $error("status high while busy");
  property p_prog_len; $fell(busy) |-> busy_len_r == PROG_CYC; endproperty
  a_prog_len: assert property (p_prog_len) else $error("cycle length wrong");
  property p_busy_start; $rose(busy) |-> prog_enabled && !cs; endproperty
  a_busy_start: assert property (p_busy_start) else $error("cycle began wrongly");
  property p_cs_gap; $rose(cs) |-> low_len_r >= 8'h7c; endproperty
  a_cs_gap: assert property (p_cs_gap) else $error("select gap too short");
  property p_idle_standby; (!cs && !busy) [*6] |-> standby; endproperty
  a_idle_standby: assert property (p_idle_standby) else $error("standby missing");
  property p_oe_release; $fell(cs) |-> ##[1:50] !serial_out_oe; endproperty
  a_oe_release: assert property (p_oe_release) else $error("output not released");
  property p_power_up; $rose(resetn) |-> !prog_enabled; endproperty
  a_power_up: assert property (p_power_up) else $error("enabled at start");
endmodule // sep_props
`default_nettype wire

// File: tb/serial_eeprom_64x16_port_test.sv
// Bench for the word memory: controller and memory joined over the link
`timescale 1ns/1ns
`default_nettype none
module serial_eeprom_64x16_port_test;
  // Shortened self-timed cycle keeps the run brief
  localparam int unsigned PROG = 200;
  logic              clk;
  logic              resetn;
  logic              cmd_valid;
  logic              cmd_ready;
  sep_pkg::sep_cmd_t cmd_kind;
  logic [5:0]        cmd_addr;
  logic [15:0]       cmd_data;
  logic              rsp_valid;
  logic [15:0]       rsp_data;
  logic              busy;
  logic              prog_enabled;
  logic              standby;
  int                miscompares = 0;
  int                num_checks = 0;
  int                cycles = 0;

  sep_if link ();
  sep_dev #(.PROG_CYC(PROG)) i_sep_dev (.clk(clk), .resetn(resetn), .link(link), .busy(busy),
    .prog_enabled(prog_enabled), .standby(standby));
  sep_host i_sep_host (.clk(clk), .resetn(resetn), .link(link), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .rsp_valid(rsp_valid), .rsp_data(rsp_data));
  sep_props #(.PROG_CYC(PROG)) i_sep_props (.clk(clk), .resetn(resetn), .cs(link.cs),
    .serial_clk(link.serial_clk), .serial_out(link.serial_out),
    .serial_out_oe(link.serial_out_oe), .busy(busy), .prog_enabled(prog_enabled),
    .standby(standby));

  // Compare and count; an unknown never matches
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One command through the user port, then wait for its completion pulse
  task automatic do_cmd(input sep_pkg::sep_cmd_t k, input logic [5:0] a, input logic [15:0] d);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 1000) begin
      @(posedge clk);
      #1;
      n++;
    end
    // A port that never becomes ready counts as a mismatch
    if (cmd_ready !== 1'b1) miscompares++;
    cmd_valid = 1'b1;
    cmd_kind = k;
    cmd_addr = a;
    cmd_data = d;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    // A command that never completes counts as a mismatch
    if (rsp_valid !== 1'b1) miscompares++;
  endtask

  // Locked at start; enable unlocks programming
  task automatic t_unlock();
    check(16'(prog_enabled), 16'h0000);
    do_cmd(sep_pkg::CMD_EN, 6'h00, 16'h0000);
    check(16'(prog_enabled), 16'h0001);
  endtask

  // Whole array erased, then one pattern into every word
  task automatic t_fill();
    do_cmd(sep_pkg::CMD_ERASE_ALL_CMD, 6'h00, 16'h0000);
    do_cmd(sep_pkg::CMD_WRITE_ALL_CMD, 6'h00, 16'h3cff);
    check(16'(busy), 16'h0000);
  endtask

  // Erase then rewrite one word; a pattern not inside the old one proves the erase
  task automatic t_rewrite();
    do_cmd(sep_pkg::CMD_ERASE, 6'h2a, 16'h0000);
    do_cmd(sep_pkg::CMD_WRITE, 6'h2a, 16'ha5c3);
    do_cmd(sep_pkg::CMD_READ, 6'h2a, 16'h0000);
    check(rsp_data, 16'ha5c3);
    do_cmd(sep_pkg::CMD_READ, 6'h3f, 16'h0000);
    check(rsp_data, 16'h3cff);
  endtask

  // Reset in mid-run: programming locks again, stored words must survive it
  task automatic t_restart();
    resetn = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_unlock();
  endtask

  // Disabled: erase ignored, reads still served
  task automatic t_locked();
    do_cmd(sep_pkg::CMD_DIS, 6'h00, 16'h0000);
    check(16'(prog_enabled), 16'h0000);
    do_cmd(sep_pkg::CMD_ERASE, 6'h3f, 16'h0000);
    do_cmd(sep_pkg::CMD_READ, 6'h3f, 16'h0000);
    check(rsp_data, 16'h3cff);
  endtask

  // Clock
  initial clk = 1'b0;
  always #4 clk = ~clk;

  // Watchdog: a hang counts as a mismatch
  always @(posedge clk) begin
    cycles++;
    if (cycles == 98000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // Main sequence
  initial begin
    resetn = 1'b0;
    cmd_valid = 1'b0;
    cmd_kind = sep_pkg::CMD_READ;
    cmd_addr = 6'h00;
    cmd_data = 16'h0000;
    repeat (5) @(posedge clk);
    #1;
    resetn = 1'b1;
    t_unlock();
    t_fill();
    t_rewrite();
    t_restart();
    t_locked();
    tally_and_finish();
  end
endmodule // serial_eeprom_64x16_port_test
`default_nettype wire
